// *** hdl/pupds_sequencer.sv ***
// Slot based power up/down sequencer with APB register access
`timescale 1ns/100ps
`default_nettype none
module pupds_sequencer #(
   parameter int TB2_CYC = pupds_pkg::TB2_CYC,
   parameter int TB3_CYC = pupds_pkg::TB3_CYC,
   parameter int SOFF_CYC = pupds_pkg::SOFF_CYC,
   parameter int DBNC_CYC = pupds_pkg::DBNC_CYC,
   parameter int HOLD_CYC = pupds_pkg::HOLD_CYC
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic power_on_pin,
   input wire logic standby_req,
   input wire logic fault_timer_expired,
   input wire logic fault_cycle_event,
   input wire logic watchdog_fail_event,
   input wire logic [1:0] default_slot_period_sel,
   input wire logic otp_power_on_edge_mode,
   input wire logic otp_shutdown_order_sel,
   input wire logic [63:0] otp_slot_codes,
   output logic [5:0] reg_enable,
   output logic power_good_pin,
   output logic host_reset_out_n,
   output logic interrupt_out_n,
   output logic fail_safe_out
);
   pupds_pkg::pupds_state_e state, next_state;
   logic [7:0] slot_code [pupds_pkg::NOUT];
   logic [6:0] out_en;
   logic [1:0] slot_period_sel;
   logic shutdown_order_sel, power_on_edge_mode, soft_off_request;
   logic [2:0] flags, mask, flag_set, flag_clr;
   logic [3:0] fault_repeat_limit, fault_repeat_count, watchdog_fail_limit, watchdog_fail_count;
   logic [5:0] stby_keep, slotted;
   logic [15:0] pcnt, period, sd_cnt, low_cnt, low_thr;
   logic [7:0] slot, last;
   logic armed, hard_dn, low_armed, pin_prev, all_zero, reloaded;
   logic active, tick, done_dn, hard, off_evt, up_evt, edge_evt, soft_exp;
   logic wr, wr_ctrl, slot_hit, mapped;
   logic [31:0] rdata;

   // APB: one wait state, writes land on the edge that samples pready
   assign wr = psel & penable & pready & pwrite;
   assign slot_hit = (paddr[7:5] == pupds_pkg::SLOT_PAGE) && (paddr[1:0] == 2'h0);
   assign wr_ctrl = wr && paddr == pupds_pkg::A_CTRL;
   assign flag_clr = (wr && paddr == pupds_pkg::A_FLAG) ? pwdata[2:0] : 3'h0;

   always_comb begin
      mapped = 1'b1;
      rdata = 32'h0;
      if (slot_hit) begin
         rdata[7:0] = slot_code[paddr[4:2]];
      end else begin
         unique case (paddr)
            pupds_pkg::A_CTRL: rdata[4:0] = {power_on_edge_mode, soft_off_request, shutdown_order_sel, slot_period_sel};
            pupds_pkg::A_FLAG: rdata[10:0] = {state, 5'h0, flags};
            pupds_pkg::A_MASK: rdata[2:0] = mask;
            pupds_pkg::A_FAULT: rdata[15:0] = {watchdog_fail_count, watchdog_fail_limit, fault_repeat_count, fault_repeat_limit};
            pupds_pkg::A_STBY: rdata[5:0] = stby_keep;
            default: mapped = 1'b0;
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0;
      end else begin
         pready <= psel & penable & !pready;
         pslverr <= psel & penable & !pready & !mapped;
         prdata <= rdata;
      end
   end

   // Software copies are reloaded on every cycle spent off
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int i = 0; i < pupds_pkg::NOUT; i++) slot_code[i] <= 8'h00;
         slot_period_sel <= 2'h0;
         shutdown_order_sel <= 1'b0;
         power_on_edge_mode <= 1'b0;
         reloaded <= 1'b0;
      end else if (state == pupds_pkg::ST_OFF) begin
         for (int i = 0; i < pupds_pkg::NOUT; i++) slot_code[i] <= otp_slot_codes[8*i +: 8];
         slot_period_sel <= default_slot_period_sel;
         shutdown_order_sel <= otp_shutdown_order_sel;
         power_on_edge_mode <= otp_power_on_edge_mode;
         reloaded <= 1'b1;
      end else begin
         reloaded <= 1'b0;
         if (wr && slot_hit) slot_code[paddr[4:2]] <= pwdata[7:0];
         if (wr_ctrl) begin
            slot_period_sel <= pwdata[1:0];
            shutdown_order_sel <= pwdata[pupds_pkg::CTRL_ORDER];
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mask <= pupds_pkg::MASK_RST;
         fault_repeat_limit <= pupds_pkg::LIMIT_RST;
         watchdog_fail_limit <= pupds_pkg::LIMIT_RST;
         stby_keep <= pupds_pkg::STBY_KEEP_RST;
      end else begin
         if (wr && paddr == pupds_pkg::A_MASK) mask <= pwdata[2:0];
         if (wr && paddr == pupds_pkg::A_STBY) stby_keep <= pwdata[5:0];
         if (wr && paddr == pupds_pkg::A_FAULT) begin
            fault_repeat_limit <= pwdata[3:0];
            watchdog_fail_limit <= pwdata[11:8];
         end
      end
   end

   // Slot timing
   always_comb begin
      unique case (slot_period_sel)
         2'h0: period = 16'(pupds_pkg::TB0_CYC);
         2'h1: period = 16'(pupds_pkg::TB1_CYC);
         2'h2: period = 16'(TB2_CYC);
         2'h3: period = 16'(TB3_CYC);
      endcase
   end
   assign active = state inside {pupds_pkg::ST_UP, pupds_pkg::ST_SUP, pupds_pkg::ST_SDN, pupds_pkg::ST_DOWN};
   assign tick = active && pcnt == period - 16'h1;
   assign done_dn = tick && armed && (shutdown_order_sel || slot == 8'h00);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pcnt <= 16'h0;
      end else if (!active || next_state != state || tick) begin
         pcnt <= 16'h0;
      end else begin
         pcnt <= pcnt + 16'h1;
      end
   end

   always_comb begin
      last = 8'h00;
      all_zero = 1'b1;
      for (int i = 0; i < pupds_pkg::NOUT; i++) begin
         if (slot_code[i] != 8'h00 && slot_code[i] - 8'h01 > last) last = slot_code[i] - 8'h01;
         if (i < pupds_pkg::IDX_RST && slot_code[i] != 8'h00) all_zero = 1'b0;
      end
   end

   // Going down the slot counts back from the last slot, one extra tick first
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         slot <= 8'h00;
         armed <= 1'b0;
      end else if (next_state != state) begin
         slot <= (next_state inside {pupds_pkg::ST_SDN, pupds_pkg::ST_DOWN}) ? last : 8'h00;
         armed <= 1'b0;
      end else if (tick) begin
         if (state inside {pupds_pkg::ST_UP, pupds_pkg::ST_SUP}) begin
            slot <= slot + 8'h01;
         end else if (!armed) begin
            armed <= 1'b1;
         end else if (slot != 8'h00) begin
            slot <= slot - 8'h01;
         end
      end
   end

   // Power-on pin events
   assign low_thr = (state == pupds_pkg::ST_OFF) ? 16'(DBNC_CYC) : 16'(HOLD_CYC);
   assign edge_evt = low_armed && !power_on_pin && low_cnt == low_thr - 16'h1;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pin_prev <= 1'b0;
         low_armed <= 1'b0;
         low_cnt <= 16'h0;
      end else begin
         pin_prev <= power_on_pin;
         if (power_on_pin || edge_evt) low_armed <= 1'b0;
         else if (pin_prev) low_armed <= 1'b1;
         low_cnt <= (low_armed && !power_on_pin) ? low_cnt + 16'h1 : 16'h0;
      end
   end

   // Software turn-off window
   assign soft_exp = soft_off_request && sd_cnt == 16'(SOFF_CYC) - 16'h1;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         soft_off_request <= 1'b0;
         sd_cnt <= 16'h0;
      end else begin
         if (state == pupds_pkg::ST_OFF || soft_exp || flag_clr[pupds_pkg::FLAG_SD]) begin
            soft_off_request <= 1'b0;
         end else if (wr_ctrl && pwdata[pupds_pkg::CTRL_SOFF]) begin
            soft_off_request <= 1'b1;
         end
         sd_cnt <= (soft_off_request && !flag_clr[pupds_pkg::FLAG_SD]) ? sd_cnt + 16'h1 : 16'h0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fault_repeat_count <= 4'h0;
         watchdog_fail_count <= 4'h0;
      end else if (state == pupds_pkg::ST_OFF) begin
         fault_repeat_count <= 4'h0;
         watchdog_fail_count <= 4'h0;
      end else begin
         if (fault_cycle_event && fault_repeat_count != 4'hF) fault_repeat_count <= fault_repeat_count + 4'h1;
         if (watchdog_fail_event && watchdog_fail_count != 4'hF) watchdog_fail_count <= watchdog_fail_count + 4'h1;
      end
   end

   assign hard = fault_timer_expired
      || (fault_repeat_count == fault_repeat_limit && fault_repeat_count != 4'h0)
      || (watchdog_fail_count == watchdog_fail_limit && watchdog_fail_count != 4'h0);
   assign off_evt = soft_exp || (power_on_edge_mode ? edge_evt : !power_on_pin);
   assign up_evt = reloaded && (power_on_edge_mode ? edge_evt : power_on_pin);
   assign slotted[0] = slot_code[0] != 8'h00;
   assign slotted[1] = slot_code[1] != 8'h00;
   assign slotted[2] = slot_code[2] != 8'h00;
   assign slotted[3] = slot_code[3] != 8'h00;
   assign slotted[4] = slot_code[4] != 8'h00;
   assign slotted[5] = slot_code[5] != 8'h00;

   always_comb begin
      next_state = state;
      unique case (state)
         pupds_pkg::ST_OFF: if (up_evt) next_state = all_zero ? pupds_pkg::ST_RUN : pupds_pkg::ST_UP;
         pupds_pkg::ST_FSAFE: next_state = pupds_pkg::ST_OFF;
         pupds_pkg::ST_DOWN: if (done_dn) next_state = hard_dn ? pupds_pkg::ST_FSAFE : pupds_pkg::ST_OFF;
         pupds_pkg::ST_UP, pupds_pkg::ST_SUP: if (tick && slot == last) next_state = pupds_pkg::ST_RUN;
         pupds_pkg::ST_RUN: if (standby_req)
            next_state = |(out_en[5:0] & ~stby_keep) ? pupds_pkg::ST_SDN : pupds_pkg::ST_STBY;
         pupds_pkg::ST_SDN: if (done_dn) next_state = pupds_pkg::ST_STBY;
         pupds_pkg::ST_STBY: if (!standby_req)
            next_state = |(~out_en[5:0] & slotted) ? pupds_pkg::ST_SUP : pupds_pkg::ST_RUN;
      endcase
      if (state inside {pupds_pkg::ST_UP, pupds_pkg::ST_RUN, pupds_pkg::ST_SDN, pupds_pkg::ST_STBY, pupds_pkg::ST_SUP}
          && (hard || off_evt)) next_state = pupds_pkg::ST_DOWN;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state <= pupds_pkg::ST_OFF;
         hard_dn <= 1'b0;
      end else begin
         state <= next_state;
         if (state != pupds_pkg::ST_DOWN && next_state == pupds_pkg::ST_DOWN) hard_dn <= hard;
      end
   end

   // Outputs 0-5 are regulators, 6 the general output; it ignores standby
   for (genvar k = 0; k < pupds_pkg::IDX_RST; k++) begin : g_out
      logic up_hit, dn_hit, keep;
      assign up_hit = slot_code[k] != 8'h00 && slot_code[k] - 8'h01 <= slot;
      assign dn_hit = slot_code[k] == 8'h00 || (armed && (shutdown_order_sel || slot_code[k] - 8'h01 >= slot));
      if (k == pupds_pkg::IDX_GPO) begin : g_keep
         assign keep = 1'b1;
      end else begin : g_keep
         assign keep = stby_keep[k];
      end
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            out_en[k] <= 1'b0;
         end else begin
            unique case (state)
               pupds_pkg::ST_UP, pupds_pkg::ST_SUP: if (up_hit) out_en[k] <= 1'b1;
               pupds_pkg::ST_SDN: if (!keep && dn_hit) out_en[k] <= 1'b0;
               pupds_pkg::ST_DOWN: if (dn_hit) out_en[k] <= 1'b0;
               pupds_pkg::ST_OFF, pupds_pkg::ST_FSAFE: out_en[k] <= 1'b0;
               pupds_pkg::ST_RUN, pupds_pkg::ST_STBY: out_en[k] <= out_en[k];
            endcase
         end
      end
   end
   assign reg_enable = out_en[5:0];
   assign power_good_pin = out_en[pupds_pkg::IDX_GPO];

   // Host reset is asserted at once on shutdown so the host stops before rails drop
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         host_reset_out_n <= 1'b0;
      end else if (state inside {pupds_pkg::ST_OFF, pupds_pkg::ST_DOWN, pupds_pkg::ST_FSAFE}) begin
         host_reset_out_n <= 1'b0;
      end else if (state == pupds_pkg::ST_RUN) begin
         host_reset_out_n <= 1'b1;
      end else if (state == pupds_pkg::ST_UP && slot_code[pupds_pkg::IDX_RST] != 8'h00
                   && slot_code[pupds_pkg::IDX_RST] - 8'h01 <= slot) begin
         host_reset_out_n <= 1'b1;
      end
   end

   // Flags: hardware set wins over a write-one clear
   always_comb begin
      flag_set = 3'h0;
      flag_set[pupds_pkg::FLAG_UP] = next_state == pupds_pkg::ST_RUN && state != pupds_pkg::ST_RUN;
      flag_set[pupds_pkg::FLAG_DN] = next_state == pupds_pkg::ST_STBY && state != pupds_pkg::ST_STBY;
      flag_set[pupds_pkg::FLAG_SD] = wr_ctrl && pwdata[pupds_pkg::CTRL_SOFF] && !soft_off_request
                                     && state != pupds_pkg::ST_OFF;
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         flags <= 3'h0;
         interrupt_out_n <= 1'b1;
         fail_safe_out <= 1'b0;
      end else begin
         flags <= (flags & ~flag_clr) | flag_set;
         interrupt_out_n <= ~|(flags & ~mask);
         fail_safe_out <= next_state == pupds_pkg::ST_FSAFE;
      end
   end

   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   chk_secondary_run: assert property (state == pupds_pkg::ST_OFF && up_evt && all_zero
      |=> state == pupds_pkg::ST_RUN ##1 host_reset_out_n && out_en == 7'h0)
      else $error("secondary mode entry wrong");
   chk_slot0_start: assert property (state == pupds_pkg::ST_UP && slot_code[0] == 8'h01 && next_state == state
      |=> reg_enable[0])
      else $error("slot 0 output not started");
   chk_zero_excluded: assert property ($rose(reg_enable[0]) |-> $past(slot_code[0]) != 8'h00)
      else $error("excluded output enabled");
   chk_up_flag: assert property (tick && state == pupds_pkg::ST_UP && slot == last && next_state == pupds_pkg::ST_RUN
      |=> flags[pupds_pkg::FLAG_UP])
      else $error("power up flag missing");
   chk_soft_flag_set: assert property (flag_set[pupds_pkg::FLAG_SD] |=> flags[pupds_pkg::FLAG_SD] && soft_off_request
      ##1 (!interrupt_out_n || mask[pupds_pkg::FLAG_SD]))
      else $error("shutdown flag or interrupt missing");
   chk_soft_expiry: assert property (soft_exp && state == pupds_pkg::ST_RUN |=> state == pupds_pkg::ST_DOWN)
      else $error("soft off expiry ignored");
   chk_tick_spacing: assert property ($rose(active) |-> !tick [*8])
      else $error("slot tick too early");
   chk_fail_safe: assert property (state == pupds_pkg::ST_DOWN && done_dn && hard_dn
      |=> state == pupds_pkg::ST_FSAFE ##1 state == pupds_pkg::ST_OFF)
      else $error("fail-safe pass skipped");
   chk_reload_off: assert property (state == pupds_pkg::ST_OFF |=> slot_period_sel == $past(default_slot_period_sel))
      else $error("time base not reloaded");
   chk_zero_down: assert property (state == pupds_pkg::ST_DOWN && slot_code[0] == 8'h00 |=> !reg_enable[0])
      else $error("zero code output not off");
   chk_fault_limit: assert property (state == pupds_pkg::ST_RUN && fault_repeat_count == fault_repeat_limit
      && fault_repeat_count != 4'h0 |=> state == pupds_pkg::ST_DOWN)
      else $error("fault limit ignored");
   cov_full_up: cover property (state == pupds_pkg::ST_UP ##1 state == pupds_pkg::ST_RUN);
   cov_stby_seq: cover property (state == pupds_pkg::ST_SDN ##1 state == pupds_pkg::ST_STBY);
   cov_soft_cancel: cover property (soft_off_request && flag_clr[pupds_pkg::FLAG_SD]);
endmodule
`default_nettype wire

// *** hdl/pupds_pkg.sv ***
// Constants, register map and state codes of the power up/down sequencer
package pupds_pkg;
   localparam int NREG = 6;
   localparam int NOUT = 8;
   localparam int IDX_GPO = 6;
   localparam int IDX_RST = 7;
   localparam int CLK_MHZ = 10;
   // Slot time bases in us and their cycle counts
   localparam int TB0_US = 30;
   localparam int TB1_US = 120;
   localparam int TB2_US = 250;
   localparam int TB3_US = 500;
   localparam int TB0_CYC = TB0_US * CLK_MHZ;
   localparam int TB1_CYC = TB1_US * CLK_MHZ;
   localparam int TB2_CYC = TB2_US * CLK_MHZ;
   localparam int TB3_CYC = TB3_US * CLK_MHZ;
   localparam int SOFF_US = 500;
   localparam int SOFF_CYC = SOFF_US * CLK_MHZ;
   localparam int DBNC_US = 1000;
   localparam int DBNC_CYC = DBNC_US * CLK_MHZ;
   localparam int HOLD_US = 2000;
   localparam int HOLD_CYC = HOLD_US * CLK_MHZ;
   // Register byte addresses
   localparam logic [7:0] A_CTRL = 8'h00;
   localparam logic [7:0] A_FLAG = 8'h04;
   localparam logic [7:0] A_MASK = 8'h08;
   localparam logic [7:0] A_FAULT = 8'h0C;
   localparam logic [7:0] A_STBY = 8'h10;
   localparam logic [2:0] SLOT_PAGE = 3'h1;
   // Field positions
   localparam int CTRL_ORDER = 2;
   localparam int CTRL_SOFF = 3;
   localparam int CTRL_EDGE = 4;
   localparam int FLAG_UP = 0;
   localparam int FLAG_DN = 1;
   localparam int FLAG_SD = 2;
   localparam int STAT_LSB = 8;
   // Reset values
   localparam logic [5:0] STBY_KEEP_RST = 6'h3F;
   localparam logic [3:0] LIMIT_RST = 4'hF;
   localparam logic [2:0] MASK_RST = 3'h0;
   typedef enum logic [2:0] {
      ST_OFF = 3'b000,
      ST_UP = 3'b001,
      ST_RUN = 3'b010,
      ST_SDN = 3'b011,
      ST_STBY = 3'b100,
      ST_SUP = 3'b101,
      ST_DOWN = 3'b110,
      ST_FSAFE = 3'b111
   } pupds_state_e;
endpackage

// *** tb/pupds_host_model.sv ***
// Host side model that drives the power-on pin
`timescale 1ns/100ps
`default_nettype none
module pupds_host_model (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic want_on,
   output logic power_on_pin
);
   // The pin follows the host's wish one edge later, never glitching between edges
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         power_on_pin <= 1'h0;
      end else begin
         power_on_pin <= want_on;
      end
   end
endmodule
`default_nettype wire

// *** tb/tb_power_up_down_sequencer.sv ***
// Self-checking bench of the power up/down sequencer
`timescale 1ns/100ps
`default_nettype none
module tb_power_up_down_sequencer;
   localparam int TBP = 20;
   logic pclk = 1'h0;
   logic presetn = 1'h0;
   logic psel = 1'h0;
   logic penable = 1'h0;
   logic pwrite = 1'h0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic power_on_pin;
   logic want_on = 1'h0;
   logic edge_mode = 1'h0;
   logic standby_req = 1'h0;
   logic fault_timer_expired = 1'h0;
   logic fault_cycle_event = 1'h0;
   logic watchdog_fail_event = 1'h0;
   logic [63:0] otp_slot_codes = 64'h0;
   logic [5:0] reg_enable;
   logic power_good_pin;
   logic host_reset_out_n;
   logic interrupt_out_n;
   logic fail_safe_out;
   logic [7:0] o;
   logic [7:0] pe = 8'h00;
   logic [5:0] en0;
   logic fs_seen = 1'h0;
   logic [31:0] rd;
   logic er;
   logic [31:0] seed = 32'h1B92B93A;
   int ton [8];
   int toff [8];
   int c [8];
   int k0;
   int cyc = 0;
   int error_cnt = 0;
   int comparisons = 0;
   always #50 pclk = ~pclk;
   assign o = {host_reset_out_n, power_good_pin, reg_enable};
   // Short time base keeps the run brief; slot gaps scale with TBP, the fixed waits do not
   pupds_sequencer #(.TB2_CYC(TBP), .TB3_CYC(TBP), .SOFF_CYC(TBP), .DBNC_CYC(TBP), .HOLD_CYC(TBP)) DUT (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .power_on_pin(power_on_pin),
      .standby_req(standby_req), .fault_timer_expired(fault_timer_expired), .fault_cycle_event(fault_cycle_event),
      .watchdog_fail_event(watchdog_fail_event), .default_slot_period_sel(2'h2), .otp_power_on_edge_mode(edge_mode),
      .otp_shutdown_order_sel(1'h0), .otp_slot_codes(otp_slot_codes), .reg_enable(reg_enable),
      .power_good_pin(power_good_pin), .host_reset_out_n(host_reset_out_n), .interrupt_out_n(interrupt_out_n),
      .fail_safe_out(fail_safe_out));
   pupds_host_model HOST (.pclk(pclk), .presetn(presetn), .want_on(want_on), .power_on_pin(power_on_pin));
   // Only the first edge of each output is kept, so a later restart cannot hide the order
   always @(posedge pclk) begin
      cyc++;
      if (fail_safe_out === 1'h1) fs_seen <= 1'h1;
      for (int i = 0; i < 8; i++) begin
         if (o[i] === 1'h1 && pe[i] === 1'h0 && ton[i] < 0) ton[i] = cyc;
         if (o[i] === 1'h0 && pe[i] === 1'h1 && toff[i] < 0) toff[i] = cyc;
      end
      pe <= o;
   end
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   function automatic int gap(input int a, input int b);
      return (a - b) * TBP;
   endfunction
   function automatic logic cond(input int s);
      case (s)
         0: return host_reset_out_n === 1'h1;
         1: return o[6:0] === 7'h00;
         default: return fs_seen === 1'h1;
      endcase
   endfunction
   task automatic chk(input logic ok, input string m);
      comparisons++;
      if (ok !== 1'h1) begin
         error_cnt++;
         $display("Error %0t: %s", $time, m);
      end
   endtask
   task automatic wt(input int k);
      repeat (k) @(posedge pclk);
   endtask
   task automatic wfor(input int s);
      int k;
      k = 0;
      while (cond(s) !== 1'h1 && k < 800) begin
         @(posedge pclk);
         k++;
      end
      chk(cond(s), "wait timed out");
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      psel <= 1'h1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'h1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'h1);
      rd = prdata;
      er = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
      @(posedge pclk);
   endtask
   task automatic conclude();
      $display("errors %0d comparisons %0d", error_cnt, comparisons);
      if (error_cnt == 0 && comparisons > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   initial begin
      wt(20000);
      error_cnt++;
      $display("Error %0t: watchdog expired", $time);
      conclude();
   end
   initial begin
      for (int i = 0; i < 8; i++) begin
         seed = lfsr(seed);
         c[i] = (i == 7) ? 0 : int'(seed[1:0]);
         ton[i] = -1;
         toff[i] = -1;
      end
      c[0] = int'(seed[2]) + 1;
      for (int i = 0; i < 8; i++) otp_slot_codes[i*8 +: 8] = 8'(c[i]);
      wt(2);
      chk(reg_enable === 6'h00 && host_reset_out_n === 1'h0 && interrupt_out_n === 1'h1, "reset values");
      wt(1);
      presetn <= 1'h1;
      want_on <= 1'h1;
      wfor(0);
      wt(3);
      for (int i = 0; i < 7; i++) begin
         if (c[i] == 0) chk(ton[i] == -1, "excluded output on");
         else chk(ton[i] - ton[0] == gap(c[i], c[0]) && ton[7] > ton[i], "start slot");
      end
      apb(1'h0, pupds_pkg::A_FLAG, 32'h0);
      chk(rd[0] === 1'h1, "power up flag");
      apb(1'h0, 8'h20, 32'h0);
      chk(rd === {24'h0, 8'(c[0])}, "slot code read");
      apb(1'h0, 8'h40, 32'h0);
      chk(er === 1'h1 && rd === 32'h0, "unmapped access");
      apb(1'h1, pupds_pkg::A_FLAG, 32'h7);
      en0 = reg_enable;
      standby_req <= 1'h1;
      wt(40);
      chk(reg_enable === en0, "standby changed enables");
      apb(1'h0, pupds_pkg::A_FLAG, 32'h0);
      chk(rd[1] === 1'h1, "power down flag");
      apb(1'h1, pupds_pkg::A_FLAG, 32'h7);
      standby_req <= 1'h0;
      wt(40);
      apb(1'h0, pupds_pkg::A_FLAG, 32'h0);
      chk(rd[0] === 1'h1, "standby exit flag");
      apb(1'h1, pupds_pkg::A_FLAG, 32'h7);
      apb(1'h1, pupds_pkg::A_CTRL, 32'hA);
      wt(3);
      chk(interrupt_out_n === 1'h0, "soft off interrupt");
      apb(1'h0, pupds_pkg::A_FLAG, 32'h0);
      chk(rd[2] === 1'h1, "shutdown flag");
      apb(1'h1, pupds_pkg::A_FLAG, 32'h4);
      wt(40);
      apb(1'h0, pupds_pkg::A_CTRL, 32'h0);
      chk(reg_enable === en0 && interrupt_out_n === 1'h1 && rd[3] === 1'h0, "cancel failed");
      k0 = c[0];
      c[0] = 5;
      apb(1'h1, 8'h20, 32'h5);
      for (int i = 0; i < 8; i++) toff[i] = -1;
      apb(1'h1, pupds_pkg::A_CTRL, 32'hA);
      wfor(1);
      wt(3);
      for (int i = 0; i < 7; i++) begin
         if (c[i] != 0) chk(toff[i] - toff[0] == gap(c[0], c[i]) && toff[7] <= toff[i], "stop order");
      end
      wfor(0);
      apb(1'h0, 8'h20, 32'h0);
      chk(rd === {24'h0, 8'(k0)}, "slot code reload");
      apb(1'h1, pupds_pkg::A_STBY, 32'h0);
      standby_req <= 1'h1;
      wt(120);
      chk(reg_enable === 6'h00, "standby kept regulators on");
      standby_req <= 1'h0;
      wt(120);
      chk(reg_enable === en0, "standby exit enables");
      apb(1'h1, pupds_pkg::A_CTRL, 32'h6);
      for (int i = 0; i < 8; i++) toff[i] = -1;
      want_on <= 1'h0;
      wfor(1);
      wt(3);
      chk(host_reset_out_n === 1'h0, "pin low shutdown");
      for (int i = 0; i < 7; i++) begin
         if (c[i] != 0) chk(toff[i] == toff[0], "group order");
      end
      otp_slot_codes <= 64'h0;
      wt(5);
      want_on <= 1'h1;
      wfor(0);
      wt(2);
      chk(reg_enable === 6'h00 && power_good_pin === 1'h0, "secondary mode outputs");
      for (int k = 0; k < 3; k++) begin
         wfor(0);
         apb(1'h1, pupds_pkg::A_FAULT, (k == 1) ? 32'h100 : 32'h1);
         fs_seen = 1'h0;
         case (k)
            0: fault_timer_expired <= 1'h1;
            1: watchdog_fail_event <= 1'h1;
            default: fault_cycle_event <= 1'h1;
         endcase
         wt(1);
         fault_timer_expired <= 1'h0;
         watchdog_fail_event <= 1'h0;
         fault_cycle_event <= 1'h0;
         wfor(2);
      end
      // Edge mode is only taken in the off state, so go down in level mode first
      wfor(0);
      edge_mode <= 1'h1;
      otp_slot_codes <= 64'h1;
      want_on <= 1'h0;
      wt(60);
      want_on <= 1'h1;
      wt(4);
      want_on <= 1'h0;
      wt(10);
      chk(host_reset_out_n === 1'h0, "edge power up too early");
      wfor(0);
      want_on <= 1'h1;
      wt(4);
      want_on <= 1'h0;
      wt(10);
      chk(host_reset_out_n === 1'h1, "hold time ignored");
      wfor(1);
      wt(60);
      chk(host_reset_out_n === 1'h0 && reg_enable === 6'h00, "restart without edge");
      conclude();
   end
endmodule
`default_nettype wire
